// File: hdl/two_wire_mgmt_bus_interface.sv
// two-wire management bus interface: byte engine, master and slave, with command fifo
`timescale 1ns/1ns

module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  // depth must be a power of two so the pointers wrap on their own
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic             ready_ff;
  wire              push = in_valid_i & ready_ff;
  wire              pop  = out_ready_i & out_valid_o;

  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ff];
  assign in_ready_o  = ready_ff;
  assign nxt_count   = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_ff <= '0;
      wr_ff    <= '0;
      rd_ff    <= '0;
      ready_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      wr_ff    <= wr_ff + {{(AW-1){1'b0}}, push};
      rd_ff    <= rd_ff + {{(AW-1){1'b0}}, pop};
      ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end
endmodule // cmd_fifo

module two_wire_mgmt_bus_interface #(
  parameter int PORT_INDEX         = two_wire_pkg::FIRST_TWO_WIRE_PORT,
  parameter int LOW_TIMEOUT_CYCLES = two_wire_pkg::LOW_TIMEOUT_CYCLES,
  parameter int FIFO_DEPTH         = two_wire_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // configuration
  input  wire two_wire_pkg::cfg_t cfg_i,
  // host commands
  input  wire logic               cmd_valid_i,
  output logic                    cmd_ready_o,
  input  wire two_wire_pkg::cmd_t cmd_i,
  // host events and status
  output logic                    evt_valid_o,
  output two_wire_pkg::evt_t      evt_o,
  output logic                    bus_busy_o,
  output logic                    master_o,
  // bus pins
  input  wire logic               scl_i,
  output logic                    scl_o,
  output logic                    scl_oe_o,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o
);
  localparam int LW = $clog2(LOW_TIMEOUT_CYCLES + 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RS_LOW, ST_RS_HIGH, ST_START, ST_HOLD, ST_BYTE, ST_ACKWAIT,
    ST_STOP_LOW, ST_STOP_HIGH, ST_SKIP
  } state_t;

  function automatic two_wire_pkg::evt_t mk_evt(two_wire_pkg::evt_kind_t k, logic [7:0] d,
                                                logic a, logic m);
    mk_evt = '{kind: k, data: d, ack: a, master: m};
  endfunction

  state_t             state_ff, nxt_state;
  logic               master_ff, nxt_master;
  logic               tx_ff, nxt_tx;
  logic               addr_ph_ff, nxt_addr_ph;
  logic               slv_act_ff, nxt_slv_act;
  logic [7:0]         sh_ff, nxt_sh;
  logic [3:0]         bit_ff, nxt_bit;
  logic               ack_out_ff, nxt_ack_out;
  logic               ack_in_ff, nxt_ack_in;
  logic               scl_low_ff, nxt_scl_low;
  logic               sda_low_ff, nxt_sda_low;
  logic               busy_ff, nxt_busy;
  logic               inhibit_ff;
  logic               evt_valid_ff, nxt_evt_valid;
  two_wire_pkg::evt_t evt_ff, nxt_evt;
  logic               scl_q_ff;
  logic               sda_q_ff;
  logic [11:0]        ph_cnt_ff;
  logic [11:0]        idle_cnt_ff;
  logic [LW-1:0]      low_cnt_ff;
  logic               cmd_take;
  logic               q_valid;
  two_wire_pkg::cmd_t q_cmd;

  cmd_fifo #(
    .WIDTH ($bits(two_wire_pkg::cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   (cmd_i),
    .out_valid_o (q_valid),
    .out_ready_i (cmd_take),
    .out_data_o  (q_cmd)
  );

  // line events; inputs are synchronous, one stage keeps the previous level
  wire scl_rise  = scl_i & ~scl_q_ff;
  wire scl_fall  = ~scl_i & scl_q_ff;
  wire start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  wire stop_det  = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  // tick period clamped so three ticks per bit never beat clk/20
  wire [11:0] tick_per  = (cfg_i.tick_div < 8'(two_wire_pkg::MIN_TICK_CYCLES)) ?
                          12'(two_wire_pkg::MIN_TICK_CYCLES) : {4'h0, cfg_i.tick_div};
  wire [11:0] low_need  = 12'(tick_per * 12'(two_wire_pkg::LOW_TICKS));
  wire [11:0] high_need = 12'(tick_per * 12'(two_wire_pkg::HIGH_TICKS));
  wire [11:0] free_need = 12'(tick_per * 12'(two_wire_pkg::FREE_TICKS));
  wire        low_done  = (ph_cnt_ff >= low_need);
  wire        high_done = (ph_cnt_ff >= high_need);
  wire        free_to   = cfg_i.free_timeout & busy_ff & (idle_cnt_ff > free_need);
  // same limit type on both ports; each instance gets its own value
  wire        low_to    = (low_cnt_ff >= LW'(LOW_TIMEOUT_CYCLES));
  wire        addr_hit  = (sh_ff[7:1] == cfg_i.own_addr);
  wire        is_read   = (sh_ff[0] == two_wire_pkg::DIR_READ);
  wire        at_ack    = (bit_ff == 4'(two_wire_pkg::ACK_BIT));
  wire        sda_want  = at_ack ? (~tx_ff & ack_out_ff) : (tx_ff & ~sh_ff[7]);
  wire        ph_clr    = (nxt_state != state_ff) | (nxt_scl_low != scl_low_ff) |
                          (~scl_i & ~scl_low_ff);

  always_comb begin
    nxt_state     = state_ff;
    nxt_master    = master_ff;
    nxt_tx        = tx_ff;
    nxt_addr_ph   = addr_ph_ff;
    nxt_slv_act   = slv_act_ff;
    nxt_sh        = sh_ff;
    nxt_bit       = bit_ff;
    nxt_ack_out   = ack_out_ff;
    nxt_ack_in    = ack_in_ff;
    nxt_scl_low   = scl_low_ff;
    nxt_sda_low   = sda_low_ff;
    nxt_evt_valid = 1'b0;
    nxt_evt       = evt_ff;
    cmd_take      = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_scl_low = 1'b0;
        nxt_sda_low = 1'b0;
        // a start waits in the fifo until the bus is free
        if (q_valid & (q_cmd.op != two_wire_pkg::CMD_START)) begin
          cmd_take = 1'b1;
        end else if (q_valid & ~busy_ff) begin
          cmd_take   = 1'b1;
          nxt_master = 1'b1;
          nxt_state  = ST_RS_HIGH;
        end
      end
      ST_RS_LOW: begin
        nxt_sda_low = 1'b0;
        if (low_done) begin
          nxt_scl_low = 1'b0;
          nxt_state   = ST_RS_HIGH;
        end
      end
      ST_RS_HIGH: begin
        if (high_done & sda_i) begin
          nxt_sda_low = 1'b1;
          nxt_state   = ST_START;
        end
      end
      ST_START: begin
        if (high_done) begin
          nxt_scl_low   = 1'b1;
          nxt_addr_ph   = 1'b1;
          nxt_bit       = 4'h0;
          nxt_state     = ST_HOLD;
          nxt_evt_valid = 1'b1;
          nxt_evt       = mk_evt(two_wire_pkg::EV_START_DONE, sh_ff, 1'b0, 1'b1);
        end
      end
      ST_HOLD: begin
        nxt_scl_low = 1'b1;
        if (~scl_i) begin
          nxt_sda_low = 1'b0;
        end
        if (q_valid) begin
          cmd_take = 1'b1;
          case (q_cmd.op)
            two_wire_pkg::CMD_WRITE: begin
              nxt_sh    = q_cmd.data;
              nxt_tx    = 1'b1;
              nxt_bit   = 4'h0;
              nxt_state = ST_BYTE;
            end
            two_wire_pkg::CMD_READ: begin
              if (master_ff) begin
                nxt_tx      = 1'b0;
                nxt_ack_out = q_cmd.ack;
                nxt_bit     = 4'h0;
                nxt_state   = ST_BYTE;
              end
            end
            two_wire_pkg::CMD_START: begin
              if (master_ff) begin
                nxt_state = ST_RS_LOW;
              end
            end
            two_wire_pkg::CMD_STOP: begin
              if (master_ff) begin
                nxt_state = ST_STOP_LOW;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_ACKWAIT: begin
        nxt_scl_low = 1'b1;
        if (q_valid) begin
          cmd_take = 1'b1;
          if (q_cmd.op == two_wire_pkg::CMD_ACK) begin
            nxt_ack_out = q_cmd.ack;
            nxt_state   = ST_BYTE;
          end
        end
      end
      ST_BYTE: begin
        if (~scl_i) begin
          nxt_sda_low = sda_want;
        end
        if (master_ff) begin
          if (scl_low_ff) begin
            nxt_scl_low = ~low_done;
          end else if (scl_fall | high_done) begin
            nxt_scl_low = 1'b1;
          end
        end else begin
          // slave lets scl go only once its data bit is on the line
          nxt_scl_low = scl_low_ff & (sda_low_ff != sda_want);
        end
        if (scl_rise) begin
          if (at_ack) begin
            nxt_ack_in = ~sda_i;
          end else begin
            nxt_sh = {sh_ff[6:0], sda_i};
            if (master_ff & tx_ff & sh_ff[7] & ~sda_i) begin
              nxt_master    = 1'b0;
              nxt_tx        = 1'b0;
              nxt_scl_low   = 1'b0;
              nxt_evt_valid = 1'b1;
              nxt_evt       = mk_evt(two_wire_pkg::EV_ARB_LOST, sh_ff, 1'b0, 1'b0);
              if (~addr_ph_ff) begin
                nxt_state = ST_SKIP;
              end
            end
          end
        end
        if (scl_fall) begin
          if (bit_ff == 4'h7) begin
            nxt_bit = 4'(two_wire_pkg::ACK_BIT);
            if (~tx_ff & ~master_ff) begin
              if (addr_ph_ff & inhibit_ff) begin
                nxt_ack_out = 1'b0;
              end else if (cfg_i.hw_ack) begin
                nxt_ack_out = ~addr_ph_ff | addr_hit;
                if (addr_ph_ff & addr_hit) begin
                  nxt_evt_valid = 1'b1;
                  nxt_evt = mk_evt(two_wire_pkg::EV_SLV_ADDR, sh_ff, 1'b1, 1'b0);
                end
              end else begin
                nxt_state     = ST_ACKWAIT;
                nxt_scl_low   = 1'b1;
                nxt_evt_valid = 1'b1;
                nxt_evt       = mk_evt(addr_ph_ff ? two_wire_pkg::EV_SLV_ADDR :
                                       two_wire_pkg::EV_RX_DATA, sh_ff, 1'b0, 1'b0);
              end
            end
          end else if (at_ack) begin
            nxt_bit     = 4'h0;
            nxt_addr_ph = 1'b0;
            if (master_ff) begin
              nxt_state     = ST_HOLD;
              nxt_evt_valid = 1'b1;
              nxt_evt       = mk_evt(tx_ff ? two_wire_pkg::EV_TX_DONE : two_wire_pkg::EV_RX_DATA,
                                     sh_ff, tx_ff ? ack_in_ff : ack_out_ff, 1'b1);
            end else if (addr_ph_ff) begin
              nxt_slv_act = ack_out_ff;
              if (~ack_out_ff) begin
                nxt_state = ST_SKIP;
              end else if (is_read) begin
                nxt_state = ST_HOLD;
              end
            end else if (tx_ff) begin
              nxt_tx        = 1'b0;
              nxt_state     = ack_in_ff ? ST_HOLD : ST_SKIP;
              nxt_evt_valid = 1'b1;
              nxt_evt       = mk_evt(two_wire_pkg::EV_TX_DONE, sh_ff, ack_in_ff, 1'b0);
            end else if (cfg_i.hw_ack) begin
              nxt_evt_valid = 1'b1;
              nxt_evt       = mk_evt(two_wire_pkg::EV_RX_DATA, sh_ff, ack_out_ff, 1'b0);
            end
          end else begin
            nxt_bit = bit_ff + 4'h1;
          end
        end
      end
      ST_STOP_LOW: begin
        nxt_scl_low = 1'b1;
        nxt_sda_low = 1'b1;
        if (low_done) begin
          nxt_scl_low = 1'b0;
          nxt_state   = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        if (high_done) begin
          nxt_sda_low = 1'b0;
          nxt_master  = 1'b0;
          nxt_state   = ST_IDLE;
        end
      end
      default: begin
        nxt_scl_low = 1'b0;
        nxt_sda_low = 1'b0;
      end
    endcase
    // foreign start: listen for an address, a master that did not make it has lost
    if (start_det & (state_ff != ST_START)) begin
      nxt_state   = ST_BYTE;
      nxt_addr_ph = 1'b1;
      nxt_slv_act = 1'b0;
      nxt_tx      = 1'b0;
      nxt_bit     = 4'h0;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      if (master_ff) begin
        nxt_master    = 1'b0;
        nxt_evt_valid = 1'b1;
        nxt_evt       = mk_evt(two_wire_pkg::EV_ARB_LOST, sh_ff, 1'b0, 1'b0);
      end
    end
    if (stop_det) begin
      nxt_state   = ST_IDLE;
      nxt_master  = 1'b0;
      nxt_slv_act = 1'b0;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      if (slv_act_ff) begin
        nxt_evt_valid = 1'b1;
        nxt_evt       = mk_evt(two_wire_pkg::EV_STOP, sh_ff, 1'b0, 1'b0);
      end
    end
    if (low_to) begin
      nxt_state     = ST_IDLE;
      nxt_master    = 1'b0;
      nxt_slv_act   = 1'b0;
      nxt_scl_low   = 1'b0;
      nxt_sda_low   = 1'b0;
      nxt_evt_valid = 1'b1;
      nxt_evt       = mk_evt(two_wire_pkg::EV_TIMEOUT, sh_ff, 1'b0, master_ff);
    end
    if (~cfg_i.enable) begin
      nxt_state     = ST_IDLE;
      nxt_master    = 1'b0;
      nxt_slv_act   = 1'b0;
      nxt_scl_low   = 1'b0;
      nxt_sda_low   = 1'b0;
      nxt_evt_valid = 1'b0;
      // no pulse, so the event word must not move either
      nxt_evt       = evt_ff;
    end
  end

  assign nxt_busy = start_det | (busy_ff & ~stop_det & ~free_to & ~low_to);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff     <= ST_IDLE;
      master_ff    <= 1'b0;
      tx_ff        <= 1'b0;
      addr_ph_ff   <= 1'b0;
      slv_act_ff   <= 1'b0;
      sh_ff        <= 8'h00;
      bit_ff       <= 4'h0;
      ack_out_ff   <= 1'b0;
      ack_in_ff    <= 1'b0;
      scl_low_ff   <= 1'b0;
      sda_low_ff   <= 1'b0;
      busy_ff      <= 1'b0;
      evt_valid_ff <= 1'b0;
      evt_ff       <= '0;
    end else begin
      state_ff     <= nxt_state;
      master_ff    <= nxt_master;
      tx_ff        <= nxt_tx;
      addr_ph_ff   <= nxt_addr_ph;
      slv_act_ff   <= nxt_slv_act;
      sh_ff        <= nxt_sh;
      bit_ff       <= nxt_bit;
      ack_out_ff   <= nxt_ack_out;
      ack_in_ff    <= nxt_ack_in;
      scl_low_ff   <= nxt_scl_low;
      sda_low_ff   <= nxt_sda_low;
      busy_ff      <= nxt_busy;
      evt_valid_ff <= nxt_evt_valid;
      evt_ff       <= nxt_evt;
    end
  end

  // line history and the three time counters
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_q_ff    <= 1'b1;
      sda_q_ff    <= 1'b1;
      inhibit_ff  <= 1'b0;
      ph_cnt_ff   <= 12'h000;
      idle_cnt_ff <= 12'h000;
      low_cnt_ff  <= '0;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
      // inhibit takes effect only from the next start
      if (start_det) begin
        inhibit_ff <= cfg_i.slave_inhibit;
      end
      if (ph_clr) begin
        ph_cnt_ff <= 12'h000;
      end else if (ph_cnt_ff != 12'hfff) begin
        ph_cnt_ff <= ph_cnt_ff + 12'h001;
      end
      if (~(scl_i & sda_i)) begin
        idle_cnt_ff <= 12'h000;
      end else if (idle_cnt_ff != 12'hfff) begin
        idle_cnt_ff <= idle_cnt_ff + 12'h001;
      end
      if (scl_i | ~cfg_i.enable | low_to) begin
        low_cnt_ff <= '0;
      end else begin
        low_cnt_ff <= low_cnt_ff + LW'(1);
      end
    end
  end

  // open drain: output level is always low, only the enables move
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_low_ff;
  assign sda_oe_o    = sda_low_ff;
  assign evt_valid_o = evt_valid_ff;
  assign evt_o       = evt_ff;
  assign bus_busy_o  = busy_ff;
  assign master_o    = master_ff;
endmodule // two_wire_mgmt_bus_interface

// File: pkg/two_wire_pkg.sv
// shared constants and carrier types for the two-wire bus interface
package two_wire_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MAX_RATE_DIV    = 20;
  localparam int TICKS_PER_BIT   = 3;
  localparam int MIN_TICK_CYCLES = (MAX_RATE_DIV + TICKS_PER_BIT - 1) / TICKS_PER_BIT;
  localparam int LOW_TICKS       = 1;
  localparam int HIGH_TICKS      = 2;
  localparam int FREE_TICKS      = 10;
  localparam int LOW_TIMEOUT_MS  = 25;
  localparam int LOW_TIMEOUT_CYCLES = LOW_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH      = 32;
  localparam int ADDR_W          = 7;
  localparam int ACK_BIT         = 8;
  localparam logic DIR_READ      = 1'b1;
  localparam int FIRST_TWO_WIRE_PORT  = 0;
  localparam int SECOND_TWO_WIRE_PORT = 1;

  typedef enum logic [2:0] {
    CMD_START, CMD_STOP, CMD_WRITE, CMD_READ, CMD_ACK
  } cmd_op_t;

  typedef struct packed {
    cmd_op_t    op;
    logic [7:0] data;
    logic       ack;
  } cmd_t;

  typedef enum logic [2:0] {
    EV_START_DONE, EV_TX_DONE, EV_RX_DATA, EV_SLV_ADDR, EV_STOP, EV_ARB_LOST, EV_TIMEOUT
  } evt_kind_t;

  typedef struct packed {
    evt_kind_t  kind;
    logic [7:0] data;
    logic       ack;
    logic       master;
  } evt_t;

  typedef struct packed {
    logic              enable;
    logic              slave_inhibit;
    logic              hw_ack;
    logic              free_timeout;
    logic [ADDR_W-1:0] own_addr;
    logic [7:0]        tick_div;
  } cfg_t;
endpackage

// File: test/bus_slave_model.sv
// behavioural write-only target device on the far side of the bus
`timescale 1ns/1ns
module bus_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  // bus levels and stretch control
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  input  wire logic  stretch_i,
  // pulls and last byte taken
  output logic       scl_oe_o,
  output logic       sda_oe_o,
  output logic [7:0] rx_o
);
  logic       scl_q, sda_q, sel_ff, first_ff;
  logic [3:0] cnt_ff;
  logic [5:0] hold_ff;
  logic [7:0] sh_ff;
  wire        addr_hit = sh_ff[7:1] == ADDR && sh_ff[0] == 1'b0;
  assign scl_oe_o = hold_ff != 6'h00;
  always_ff @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    hold_ff <= (hold_ff != 6'h00) ? hold_ff - 6'h01 : 6'h00;
    if (reset_i) begin
      {sel_ff, first_ff, cnt_ff, sda_oe_o, rx_o, hold_ff} <= '0;
    end else if (scl_i && scl_q && sda_q != sda_i) begin
      cnt_ff   <= 4'h0;
      first_ff <= !sda_i;
      sel_ff   <= 1'b0;
    end else if (scl_i && !scl_q) begin
      sh_ff  <= {sh_ff[6:0], sda_i};
      cnt_ff <= cnt_ff + 4'h1;
    end else if (!scl_i && scl_q) begin
      // pulls change only after scl fell
      hold_ff <= stretch_i ? 6'h28 : 6'h00;
      if (cnt_ff == 4'h8) begin
        rx_o     <= sh_ff;
        first_ff <= 1'b0;
        sel_ff   <= first_ff ? addr_hit : sel_ff;
        // reads are not served, so a read address is left unanswered
        sda_oe_o <= first_ff ? addr_hit : sel_ff;
      end else begin
        sda_oe_o <= 1'b0;
        cnt_ff   <= (cnt_ff == 4'h9) ? 4'h0 : cnt_ff;
      end
    end
  end
endmodule // bus_slave_model

// File: test/test_two_wire_mgmt_bus_interface.sv
// self-checking bench: interface as master against the target model
`timescale 1ns/1ns
module test_two_wire_mgmt_bus_interface;
  localparam logic [6:0] MODEL_ADDR = 7'h2a;
  logic               clk_i, reset_i, cmd_valid, cmd_ready, evt_valid, busy, master;
  logic               scl_oe, sda_oe, m_scl_oe, m_sda_oe, tb_sda_oe, stretch;
  logic [7:0]         rx;
  two_wire_pkg::cfg_t cfg;
  two_wire_pkg::cmd_t cmd;
  two_wire_pkg::evt_t evt;
  wire                scl = !(scl_oe || m_scl_oe);
  wire                sda = !(sda_oe || m_sda_oe || tb_sda_oe);
  int                 bad_count = 0;
  int                 checks_done = 0;

  two_wire_mgmt_bus_interface #(.LOW_TIMEOUT_CYCLES(2000)) i_two_wire_mgmt_bus_interface (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_i(cmd), .evt_valid_o(evt_valid), .evt_o(evt),
    .bus_busy_o(busy), .master_o(master), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
  bus_slave_model #(.ADDR(MODEL_ADDR)) i_bus_slave_model (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .stretch_i(stretch),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .rx_o(rx));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timed_out(string what);
    bad_count++;
    $display("wrong value %s expected done seen timeout", what);
    complete_run();
  endtask
  task automatic push(two_wire_pkg::cmd_op_t op, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd       <= '{op: op, data: d, ack: 1'b1};
    cmd_valid <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    if (n >= 100) timed_out("command accept");
  endtask
  // events stand one cycle, so every cycle is looked at
  task automatic wait_evt(two_wire_pkg::evt_kind_t kind, string what);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (evt_valid !== 1'b1 && n < 3000);
    if (n >= 3000) timed_out(what);
    cmp_byte(what, 8'(kind), 8'(evt.kind));
  endtask
  task automatic wait_idle(string what);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 3000) timed_out(what);
  endtask
  task automatic start_addr(logic [7:0] abyte);
    push(two_wire_pkg::CMD_START, 8'h00);
    wait_evt(two_wire_pkg::EV_START_DONE, "start done");
    cmp_bit("master", 1'b1, master);
    push(two_wire_pkg::CMD_WRITE, abyte);
    wait_evt(two_wire_pkg::EV_TX_DONE, "address sent");
    cmp_byte("address echo", abyte, evt.data);
  endtask

  task automatic t_idle;
    cmp_bit("scl pull", 1'b0, scl_oe);
    cmp_bit("sda pull", 1'b0, sda_oe);
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("ready", 1'b1, cmd_ready);
  endtask
  task automatic t_write;
    start_addr({MODEL_ADDR, 1'b0});
    cmp_bit("address ack", 1'b1, evt.ack);
    @(posedge clk_i);
    stretch <= 1'b1;
    push(two_wire_pkg::CMD_WRITE, 8'ha5);
    wait_evt(two_wire_pkg::EV_TX_DONE, "data sent");
    cmp_bit("data ack", 1'b1, evt.ack);
    cmp_byte("target byte", 8'ha5, rx);
    stretch <= 1'b0;
    push(two_wire_pkg::CMD_STOP, 8'h00);
    wait_idle("stop");
    cmp_bit("master after stop", 1'b0, master);
  endtask
  // wrong address, then right address with the read flag the model refuses
  task automatic t_refuse;
    for (int i = 0; i < 2; i++) begin
      start_addr(i == 0 ? {MODEL_ADDR ^ 7'h01, 1'b0} : {MODEL_ADDR, 1'b1});
      cmp_bit("refused ack", 1'b0, evt.ack);
      push(two_wire_pkg::CMD_STOP, 8'h00);
      wait_idle("stop after refusal");
    end
  endtask
  task automatic t_arb;
    push(two_wire_pkg::CMD_START, 8'h00);
    wait_evt(two_wire_pkg::EV_START_DONE, "second start");
    push(two_wire_pkg::CMD_WRITE, 8'hff);
    tb_sda_oe <= 1'b1;
    wait_evt(two_wire_pkg::EV_ARB_LOST, "arbitration");
    cmp_bit("master after loss", 1'b0, master);
    @(posedge clk_i);
    tb_sda_oe <= 1'b0;
    wait_idle("bus free after loss");
  endtask
  task automatic t_timeout;
    push(two_wire_pkg::CMD_START, 8'h00);
    wait_evt(two_wire_pkg::EV_START_DONE, "start before hang");
    wait_evt(two_wire_pkg::EV_TIMEOUT, "low timeout");
    wait_idle("idle after timeout");
    cmp_bit("scl released", 1'b0, scl_oe);
  endtask
  // engine switched off mid-transfer: lines float high, only free timeout ends busy
  task automatic t_free;
    push(two_wire_pkg::CMD_START, 8'h00);
    wait_evt(two_wire_pkg::EV_START_DONE, "start before release");
    @(posedge clk_i);
    cfg.enable <= 1'b0;
    wait_idle("free timeout");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    reset_i   = 1'b1;
    cfg       = '{enable: 1'b1, slave_inhibit: 1'b0, hw_ack: 1'b0, free_timeout: 1'b1,
                  own_addr: 7'h11, tick_div: 8'h07};
    cmd_valid = 1'b0;
    cmd       = '0;
    tb_sda_oe = 1'b0;
    stretch   = 1'b0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    t_idle();
    t_write();
    t_refuse();
    t_arb();
    t_timeout();
    t_free();
    complete_run();
  end
endmodule // test_two_wire_mgmt_bus_interface

// File: test/two_wire_mgmt_bus_interface_properties.sv
// port-level assertion checker for the two-wire bus interface
`timescale 1ns/1ns
module two_wire_checker #(
  parameter int LOW_TIMEOUT_CYCLES = 2000
) (
  // clock, reset and configuration
  input wire logic               clk_i,
  input wire logic               reset_i,
  input wire two_wire_pkg::cfg_t cfg_i,
  // host side
  input wire logic               evt_valid_o,
  input wire two_wire_pkg::evt_t evt_o,
  input wire logic               bus_busy_o,
  input wire logic               master_o,
  // bus pins
  input wire logic               scl_i,
  input wire logic               scl_o,
  input wire logic               scl_oe_o,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o
);
  int lo_ff;
  int hi_ff;
  int tick;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // clock source period is clamped up to 7 cycles
  assign tick = (cfg_i.tick_div < 8'h07) ? 7 : int'(cfg_i.tick_div);
  always_ff @(posedge clk_i) begin
    lo_ff <= (scl_i || reset_i) ? 0 : lo_ff + 1;
    hi_ff <= (scl_i && sda_i && !reset_i) ? hi_ff + 1 : 0;
  end
  sequence s_master_release;
    master_o && $fell(scl_oe_o);
  endsequence
  sequence s_held_by_other;
    master_o && !scl_oe_o && !scl_i && !$past(scl_i);
  endsequence
  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_evt_hold;
    !evt_valid_o |-> $stable(evt_o);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event moved");
  property p_start_done;
    evt_valid_o && evt_o.kind == two_wire_pkg::EV_START_DONE |-> master_o && bus_busy_o;
  endproperty
  a_start_done: assert property (p_start_done) else $error("start not owned");
  property p_start_shape;
    !bus_busy_o && $rose(sda_oe_o) |-> scl_i ##[1:3] bus_busy_o;
  endproperty
  a_start_shape: assert property (p_start_shape) else $error("bad start");
  property p_low_min;
    master_o && $rose(scl_oe_o) |=> scl_oe_o [*6];
  endproperty
  a_low_min: assert property (p_low_min) else $error("scl low short");
  property p_high_min;
    s_master_release |=> !scl_oe_o [*8];
  endproperty
  a_high_min: assert property (p_high_min) else $error("scl high short");
  property p_stretch;
    s_held_by_other |=> !scl_oe_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch ignored");
  property p_timeout;
    evt_valid_o && evt_o.kind == two_wire_pkg::EV_TIMEOUT
      |-> lo_ff >= LOW_TIMEOUT_CYCLES - 2 && lo_ff <= LOW_TIMEOUT_CYCLES + 2;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout mistimed");
  property p_free;
    cfg_i.free_timeout && hi_ff == 10 * tick + 4 |-> !bus_busy_o;
  endproperty
  a_free: assert property (p_free) else $error("bus not freed");
  property p_arb;
    evt_valid_o && evt_o.kind == two_wire_pkg::EV_ARB_LOST |-> ##[0:1] (!master_o && !sda_oe_o);
  endproperty
  a_arb: assert property (p_arb) else $error("loser kept bus");
endmodule // two_wire_checker

bind two_wire_mgmt_bus_interface two_wire_checker #(
  .LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES)
) i_two_wire_checker (
  .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i), .evt_valid_o(evt_valid_o),
  .evt_o(evt_o), .bus_busy_o(bus_busy_o), .master_o(master_o), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);
